// ---- rtl/dlt_defines.svh ----
`ifndef DLT_DEFINES_SVH
`define DLT_DEFINES_SVH

// register byte offsets on the bus
`define DLT_OFS_CONTROL 8'h00
`define DLT_OFS_MODE 8'h04
`define DLT_OFS_CLOCK 8'h08
`define DLT_OFS_T0_LOW 8'h0c
`define DLT_OFS_T0_HIGH 8'h10
`define DLT_OFS_T1_LOW 8'h14
`define DLT_OFS_T1_HIGH 8'h18
`define DLT_OFS_IRQ_CFG 8'h1c

// control register fields
`define DLT_CTL_FLAG1 7
`define DLT_CTL_RUN1 6
`define DLT_CTL_FLAG0 5
`define DLT_CTL_RUN0 4

// mode register fields (mode fields give their low bit)
`define DLT_MOD_TIMER1_GATING_SELECT 7
`define DLT_MOD_CSEL1 6
`define DLT_MOD_MODE1 4
`define DLT_MOD_TIMER0_GATING_SELECT 3
`define DLT_MOD_CSEL0 2
`define DLT_MOD_MODE0 0

// clock register fields
`define DLT_CLK_SYS1 3
`define DLT_CLK_SYS0 2
`define DLT_CLK_PRESCALE 0

// interrupt configuration fields
`define DLT_IRQ_POL1 3
`define DLT_IRQ_POL0 2
`define DLT_IRQ_EN1 1
`define DLT_IRQ_EN0 0

// reset values
`define DLT_RST_BYTE 8'h00

// prescaler divisors and the external divide-by-8 terminal count
`define DLT_DIV_12 6'h0c
`define DLT_DIV_4 6'h04
`define DLT_DIV_48 6'h30
`define DLT_EXT_LAST 3'h7

// bus responses
`define DLT_RESP_OKAY 2'h0
`define DLT_RESP_SLVERR 2'h2

`endif

// ---- rtl/dlt_pkg.sv ----
package dlt_pkg;

	typedef enum logic [1:0] {
		dlt_mode_13bit = 2'b00,
		dlt_mode_16bit = 2'b01,
		dlt_mode_reload = 2'b10,
		dlt_mode_split = 2'b11
	} dlt_mode_type;

	typedef enum logic [1:0] {
		dlt_pre_div12 = 2'b00,
		dlt_pre_div4 = 2'b01,
		dlt_pre_div48 = 2'b10,
		dlt_pre_ext8 = 2'b11
	} dlt_prescale_type;

	typedef struct packed {
		logic run;
		logic gate;
		logic count_sel;
		logic sysclk_sel;
		logic irq_en;
		logic polarity;
		dlt_mode_type mode;
	} dlt_timer_cfg_type;

	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} dlt_count_type;

	typedef struct packed {
		logic ovf;
		dlt_count_type cnt;
	} dlt_step_type;

endpackage

// ---- rtl/dlt_prescaler.sv ----
`timescale 1ns/1ps
`include "dlt_defines.svh"

module dlt_prescaler
	import dlt_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire dlt_prescale_type prescale_field,
	input wire logic ext_clk,
	output logic tick
);

	logic [5:0] div_cnt;
	logic [5:0] next_div_cnt;
	logic [5:0] limit;
	logic [2:0] ext_sync;
	logic [2:0] ext_cnt;
	logic [2:0] next_ext_cnt;
	logic next_tick;

	always_comb begin
		next_div_cnt = div_cnt;
		next_ext_cnt = ext_cnt;
		next_tick = 1'b0;
		unique case (prescale_field)
			dlt_pre_div12: limit = `DLT_DIV_12;
			dlt_pre_div4: limit = `DLT_DIV_4;
			dlt_pre_div48: limit = `DLT_DIV_48;
			dlt_pre_ext8: limit = `DLT_DIV_4;
		endcase
		if (prescale_field == dlt_pre_ext8) begin
			// external clock is resynchronised, rising edges counted
			next_div_cnt = 6'h00;
			if (ext_sync[1] && !ext_sync[2]) begin // [RULE_19]
				next_ext_cnt = ext_cnt + 3'h1;
				next_tick = (ext_cnt == `DLT_EXT_LAST);
			end
		end else if (div_cnt >= limit - 6'h01) begin // [RULE_19]
			next_div_cnt = 6'h00;
			next_tick = 1'b1;
		end else begin
			next_div_cnt = div_cnt + 6'h01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt <= 6'h00;
			ext_cnt <= 3'h0;
			ext_sync <= 3'h0;
			tick <= 1'b0;
		end else if (clk_en) begin
			div_cnt <= next_div_cnt;
			ext_cnt <= next_ext_cnt;
			ext_sync <= {ext_sync[1:0], ext_clk};
			tick <= next_tick;
		end
	end

	chk_prescale_div4: assert property (@(posedge aclk) disable iff (!aresetn)
		(tick && clk_en && prescale_field == dlt_pre_div4) ##1
		(clk_en && prescale_field == dlt_pre_div4)[*3] |=> tick) // [RULE_19]
		else $error("prescaled tick not every fourth cycle");

endmodule

// ---- rtl/dlt_timers.sv ----
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "dlt_defines.svh"
// Behaviour
// [RULE_01] counter function adds one per falling edge on the count pin
// [RULE_02] external events up to a quarter of the system clock are counted
// [RULE_03] the event source holds each level at least two system clocks
// [RULE_04] each timer is 16 bits, reached as separate low and high bytes
// [RULE_05] mode 0 uses high byte and low bits 4..0; low bits 7..5 ignored
// [RULE_06] mode 0 wrap from all ones sets the overflow flag
// [RULE_07] timer function counts system clock or prescaled clock per select
// [RULE_08] count only with run set and gate off or gating input active
// [RULE_09] setting run neither clears nor reloads the count
// [RULE_10] timer 1 mirrors timer 0 in modes 0..2 with its own bits
// [RULE_11] mode 1 counts all 16 bits and flags on wrap
// [RULE_12] mode 2 low byte counts, reloads from high byte on overflow
// [RULE_13] software loads the low byte before enabling mode 2
// [RULE_14] split mode low byte uses timer 0 controls and flag
// [RULE_15] split high byte counts clocks, runs on timer 1 run, sets flag 1
// [RULE_16] in split mode timer 1 takes no pin, sets no flag, still overflows
// [RULE_17] in split mode timer 1 runs in modes 0..2 and stops in mode 3
// [RULE_18] interrupt request needs flag and enable; modes set independently
// [RULE_19] prescale 00 /12, 01 /4, 10 /48, 11 external clock /8
// [RULE_20] mode field: 13-bit, 16-bit, reload, split or inactive
// [RULE_21] flags clear by software write or by interrupt vectoring
// [RULE_22] count pins are synchronised and falling edges detected

module dlt_timers
	import dlt_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic timer0_count_pin,
	input wire logic timer1_count_pin,
	input wire logic gating_input_zero,
	input wire logic gating_input_one,
	input wire logic ext_clk,
	input wire logic timer0_irq_ack,
	input wire logic timer1_irq_ack,
	output logic timer0_irq,
	output logic timer1_irq,
	output logic timer1_overflow_pulse
);

	function automatic logic dlt_mapped(input logic [7:0] a);
		return a == `DLT_OFS_CONTROL || a == `DLT_OFS_MODE ||
			a == `DLT_OFS_CLOCK || a == `DLT_OFS_T0_LOW ||
			a == `DLT_OFS_T0_HIGH || a == `DLT_OFS_T1_LOW ||
			a == `DLT_OFS_T1_HIGH || a == `DLT_OFS_IRQ_CFG;
	endfunction

	// one count step for modes 0..3 of the low/whole register
	function automatic dlt_step_type dlt_step(input dlt_mode_type m,
		input dlt_count_type c);
		dlt_step_type r;
		r.ovf = 1'b0;
		r.cnt = c;
		unique case (m)
			dlt_mode_13bit: begin
				{r.ovf, r.cnt.high, r.cnt.low[4:0]} =
					{1'b0, c.high, c.low[4:0]} + 14'h0001; // [RULE_05] [RULE_06]
			end
			dlt_mode_16bit: begin
				{r.ovf, r.cnt} = {1'b0, c} + 17'h00001; // [RULE_11]
			end
			dlt_mode_reload: begin
				{r.ovf, r.cnt.low} = {1'b0, c.low} + 9'h001;
				if (r.ovf) begin
					r.cnt.low = c.high; // [RULE_12]
				end
			end
			dlt_mode_split: begin
				{r.ovf, r.cnt.low} = {1'b0, c.low} + 9'h001; // [RULE_14]
			end
		endcase
		return r;
	endfunction

	dlt_timer_cfg_type cfg0, cfg1, next_cfg0, next_cfg1;
	dlt_prescale_type prescale, next_prescale;
	dlt_count_type cnt0, cnt1, next_cnt0, next_cnt1;
	dlt_step_type step0, step1;
	logic flag0, flag1, next_flag0, next_flag1;
	logic next_t1_pulse;
	logic presc_tick;
	logic [2:0] pin_sync [2];
	logic [1:0] pin_fall;
	logic [1:0] pin_in;
	logic t0_split, t0_go, t1_go, th0_go, th0_ovf, t0_ovf, t1_ovf;
	logic tick0, tick1, en0, en1, set0, set1;

	// bus state
	logic aw_held, w_held, next_aw_held, next_w_held;
	logic [7:0] aw_addr, next_aw_addr;
	logic [7:0] w_data, next_w_data;
	logic w_lane0, next_w_lane0;
	logic bvalid, next_bvalid, rvalid, next_rvalid;
	logic [1:0] bresp, next_bresp, rresp, next_rresp;
	logic [7:0] rdata, next_rdata;
	logic do_wr, wr_en;
	logic wr_ctl, wr_mode, wr_clk, wr_irq, wr_t0l, wr_t0h, wr_t1l, wr_t1h;

	dlt_prescaler u_prescaler (
		.aclk(aclk),
		.aresetn(aresetn),
		.clk_en(clk_en),
		.prescale_field(prescale),
		.ext_clk(ext_clk),
		.tick(presc_tick)
	);

	assign pin_in = {timer1_count_pin, timer0_count_pin};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_pin
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					pin_sync[gi] <= 3'h7;
				end else if (clk_en) begin
					pin_sync[gi] <= {pin_sync[gi][1:0], pin_in[gi]};
				end
			end
			// one-cycle enable per high-to-low step
			assign pin_fall[gi] = pin_sync[gi][2] && !pin_sync[gi][1]; // [RULE_22] [RULE_02]
		end
	endgenerate

	assign t0_split = (cfg0.mode == dlt_mode_split);
	assign tick0 = cfg0.count_sel ? pin_fall[0] :
		(cfg0.sysclk_sel ? 1'b1 : presc_tick); // [RULE_07] [RULE_01]
	assign tick1 = (cfg1.count_sel && !t0_split) ? pin_fall[1] :
		(cfg1.sysclk_sel ? 1'b1 : presc_tick); // [RULE_10] [RULE_16]
	assign en0 = cfg0.run &&
		(!cfg0.gate || gating_input_zero == cfg0.polarity); // [RULE_08]
	assign en1 = t0_split ? (cfg1.mode != dlt_mode_split) : // [RULE_17]
		(cfg1.run && cfg1.mode != dlt_mode_split &&
		(!cfg1.gate || gating_input_one == cfg1.polarity)); // [RULE_10] [RULE_20]
	assign t0_go = en0 && tick0;
	assign t1_go = en1 && tick1;
	assign th0_go = t0_split && cfg1.run &&
		(cfg0.sysclk_sel ? 1'b1 : presc_tick); // [RULE_15]
	assign th0_ovf = th0_go && cnt0.high == 8'hff;
	assign step0 = dlt_step(cfg0.mode, cnt0);
	assign step1 = dlt_step(cfg1.mode, cnt1);
	assign t0_ovf = t0_go && step0.ovf;
	assign t1_ovf = t1_go && step1.ovf;
	assign set0 = t0_ovf;
	assign set1 = t0_split ? th0_ovf : t1_ovf; // [RULE_15] [RULE_16]

	assign timer0_irq = flag0 && cfg0.irq_en; // [RULE_18]
	assign timer1_irq = flag1 && cfg1.irq_en; // [RULE_18]

	assign do_wr = aw_held && w_held && !bvalid;
	assign wr_en = do_wr && w_lane0;
	assign wr_ctl = wr_en && aw_addr == `DLT_OFS_CONTROL;
	assign wr_mode = wr_en && aw_addr == `DLT_OFS_MODE;
	assign wr_clk = wr_en && aw_addr == `DLT_OFS_CLOCK;
	assign wr_irq = wr_en && aw_addr == `DLT_OFS_IRQ_CFG;
	assign wr_t0l = wr_en && aw_addr == `DLT_OFS_T0_LOW;
	assign wr_t0h = wr_en && aw_addr == `DLT_OFS_T0_HIGH;
	assign wr_t1l = wr_en && aw_addr == `DLT_OFS_T1_LOW;
	assign wr_t1h = wr_en && aw_addr == `DLT_OFS_T1_HIGH;

	always_comb begin
		next_cfg0 = cfg0;
		next_cfg1 = cfg1;
		next_prescale = prescale;
		next_cnt0 = cnt0;
		next_cnt1 = cnt1;
		next_flag0 = flag0;
		next_flag1 = flag1;
		next_t1_pulse = t1_ovf; // [RULE_16]
		if (t0_go) begin
			next_cnt0 = step0.cnt; // [RULE_14]
		end
		if (th0_go) begin
			next_cnt0.high = cnt0.high + 8'h01; // [RULE_15]
		end
		if (t1_go) begin
			next_cnt1 = step1.cnt; // [RULE_10]
		end
		// run bit writes leave the counts alone
		if (wr_ctl) begin
			next_cfg1.run = w_data[`DLT_CTL_RUN1]; // [RULE_09]
			next_cfg0.run = w_data[`DLT_CTL_RUN0]; // [RULE_09]
		end
		if (wr_mode) begin
			next_cfg1.gate = w_data[`DLT_MOD_TIMER1_GATING_SELECT];
			next_cfg1.count_sel = w_data[`DLT_MOD_CSEL1];
			next_cfg1.mode = dlt_mode_type'(w_data[`DLT_MOD_MODE1 +: 2]); // [RULE_20]
			next_cfg0.gate = w_data[`DLT_MOD_TIMER0_GATING_SELECT];
			next_cfg0.count_sel = w_data[`DLT_MOD_CSEL0];
			next_cfg0.mode = dlt_mode_type'(w_data[`DLT_MOD_MODE0 +: 2]); // [RULE_18]
		end
		if (wr_clk) begin
			next_cfg1.sysclk_sel = w_data[`DLT_CLK_SYS1];
			next_cfg0.sysclk_sel = w_data[`DLT_CLK_SYS0];
			next_prescale =
				dlt_prescale_type'(w_data[`DLT_CLK_PRESCALE +: 2]); // [RULE_19]
		end
		if (wr_irq) begin
			next_cfg1.polarity = w_data[`DLT_IRQ_POL1];
			next_cfg0.polarity = w_data[`DLT_IRQ_POL0];
			next_cfg1.irq_en = w_data[`DLT_IRQ_EN1];
			next_cfg0.irq_en = w_data[`DLT_IRQ_EN0];
		end
		// software byte writes win over counting
		if (wr_t0l) next_cnt0.low = w_data; // [RULE_04]
		if (wr_t0h) next_cnt0.high = w_data; // [RULE_04]
		if (wr_t1l) next_cnt1.low = w_data;
		if (wr_t1h) next_cnt1.high = w_data;
		// flags: clear by vectoring or write, hardware set wins
		if (timer0_irq_ack) next_flag0 = 1'b0; // [RULE_21]
		if (timer1_irq_ack) next_flag1 = 1'b0; // [RULE_21]
		if (wr_ctl) begin
			next_flag1 = w_data[`DLT_CTL_FLAG1];
			next_flag0 = w_data[`DLT_CTL_FLAG0];
		end
		if (set0) next_flag0 = 1'b1; // [RULE_06] [RULE_11] [RULE_12]
		if (set1) next_flag1 = 1'b1; // [RULE_15]
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg0 <= '0;
			cfg1 <= '0;
			prescale <= dlt_pre_div12;
			cnt0 <= {`DLT_RST_BYTE, `DLT_RST_BYTE};
			cnt1 <= {`DLT_RST_BYTE, `DLT_RST_BYTE};
			flag0 <= 1'b0;
			flag1 <= 1'b0;
			timer1_overflow_pulse <= 1'b0;
		end else if (clk_en) begin
			cfg0 <= next_cfg0;
			cfg1 <= next_cfg1;
			prescale <= next_prescale;
			cnt0 <= next_cnt0;
			cnt1 <= next_cnt1;
			flag0 <= next_flag0;
			flag1 <= next_flag1;
			timer1_overflow_pulse <= next_t1_pulse;
		end
	end

	// bus slave: handshakes stall while the clock enable is low
	assign s_axi_awready = !aw_held && clk_en;
	assign s_axi_wready = !w_held && clk_en;
	assign s_axi_arready = !rvalid && clk_en;
	assign s_axi_bvalid = bvalid && clk_en;
	assign s_axi_rvalid = rvalid && clk_en;
	assign s_axi_bresp = bresp;
	assign s_axi_rresp = rresp;
	assign s_axi_rdata = {24'h000000, rdata};

	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held = w_held;
		next_w_data = w_data;
		next_w_lane0 = w_lane0;
		next_bvalid = bvalid;
		next_bresp = bresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = {s_axi_awaddr[7:2], 2'b00};
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata[7:0];
			next_w_lane0 = s_axi_wstrb[0];
		end
		if (bvalid && s_axi_bready) next_bvalid = 1'b0;
		if (do_wr) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = dlt_mapped(aw_addr) ? `DLT_RESP_OKAY : `DLT_RESP_SLVERR;
		end
	end

	always_comb begin
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (rvalid && s_axi_rready) next_rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp = dlt_mapped({s_axi_araddr[7:2], 2'b00}) ?
				`DLT_RESP_OKAY : `DLT_RESP_SLVERR;
			unique case ({s_axi_araddr[7:2], 2'b00})
				`DLT_OFS_CONTROL: next_rdata =
					{flag1, cfg1.run, flag0, cfg0.run, 4'h0};
				`DLT_OFS_MODE: next_rdata = {cfg1.gate, cfg1.count_sel,
					cfg1.mode, cfg0.gate, cfg0.count_sel, cfg0.mode};
				`DLT_OFS_CLOCK: next_rdata =
					{4'h0, cfg1.sysclk_sel, cfg0.sysclk_sel, prescale};
				`DLT_OFS_T0_LOW: next_rdata = cnt0.low;
				`DLT_OFS_T0_HIGH: next_rdata = cnt0.high;
				`DLT_OFS_T1_LOW: next_rdata = cnt1.low;
				`DLT_OFS_T1_HIGH: next_rdata = cnt1.high;
				`DLT_OFS_IRQ_CFG: next_rdata = {4'h0, cfg1.polarity,
					cfg0.polarity, cfg1.irq_en, cfg0.irq_en};
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
			w_held <= 1'b0;
			w_data <= 8'h00;
			w_lane0 <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `DLT_RESP_OKAY;
			rvalid <= 1'b0;
			rdata <= 8'h00;
			rresp <= `DLT_RESP_OKAY;
		end else if (clk_en) begin
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held <= next_w_held;
			w_data <= next_w_data;
			w_lane0 <= next_w_lane0;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_pin_edge_count: assert property (clk_en && pin_fall[0] && en0 && // [RULE_01]
		cfg0.count_sel && cfg0.mode == dlt_mode_16bit && !wr_t0l && !wr_t0h
		|=> cnt0 == 16'($past(cnt0) + 16'h0001))
		else $error("external edge did not advance timer 0");
	chk_gate_hold: assert property (clk_en && !en0 && !t0_split && // [RULE_08]
		!wr_t0l && !wr_t0h |=> $stable(cnt0))
		else $error("timer 0 moved while disabled");
	chk_mode0_wrap: assert property (clk_en && t0_go && // [RULE_06]
		cfg0.mode == dlt_mode_13bit && cnt0.high == 8'hff &&
		cnt0.low[4:0] == 5'h1f && !wr_t0l && !wr_t0h && !timer0_irq_ack
		|=> flag0 && cnt0.high == 8'h00 && cnt0.low[4:0] == 5'h00)
		else $error("13-bit wrap not flagged");
	chk_mode2_reload: assert property (clk_en && t0_go && // [RULE_12]
		cfg0.mode == dlt_mode_reload && cnt0.low == 8'hff &&
		!wr_t0l && !wr_t0h && !timer0_irq_ack
		|=> flag0 && cnt0.low == $past(cnt0.high) && $stable(cnt0.high))
		else $error("reload not taken from high byte");
	chk_split_high: assert property (clk_en && th0_go && // [RULE_15]
		cnt0.high == 8'hff && !timer1_irq_ack && !wr_ctl |=> flag1)
		else $error("split high byte overflow did not set flag 1");
	chk_t1_no_flag: assert property (clk_en && t0_split && !th0_ovf && // [RULE_16]
		!flag1 && !wr_ctl ##1 clk_en |-> !flag1)
		else $error("timer 1 set its flag in split mode");
	chk_t1_stop: assert property (clk_en && cfg1.mode == dlt_mode_split && // [RULE_17]
		!wr_t1l && !wr_t1h |=> $stable(cnt1))
		else $error("timer 1 counted in mode 3");
	chk_irq_gate: assert property (timer0_irq |-> flag0 && cfg0.irq_en) // [RULE_18]
		else $error("timer 0 request without flag and enable");
	chk_ack_clear: assert property (clk_en && timer0_irq_ack && !set0 && // [RULE_21]
		!wr_ctl |=> !flag0)
		else $error("vectoring did not clear flag 0");
	chk_run_keeps: assert property (clk_en && wr_ctl && // [RULE_09]
		!t0_go && !th0_go && !wr_t0l && !wr_t0h |=> $stable(cnt0))
		else $error("run write disturbed timer 0 count");

	cov_ext_count: cover property (clk_en && pin_fall[0] && t0_go);
	cov_reload: cover property (t0_ovf && cfg0.mode == dlt_mode_reload);
	cov_split_ovf: cover property (th0_ovf && clk_en);
	cov_t1_ovf: cover property (t1_ovf && !t0_split && clk_en);

endmodule

// ---- tb/dlt_event_model.sv ----
`timescale 1ns/1ps
module dlt_event_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic req0,
	input wire logic req1,
	input wire logic ext_run,
	output logic timer0_count_pin,
	output logic timer1_count_pin,
	output logic ext_clk
);
	logic [1:0] ph0;
	logic [1:0] ph1;
	logic [1:0] phx;
	// each level held two clocks, so one fall per four clocks
	always_ff @(posedge aclk) begin
		ph0 <= (aresetn && req0) ? ph0 + 2'h1 : 2'h0;
		ph1 <= (aresetn && req1) ? ph1 + 2'h1 : 2'h0;
		if (!aresetn)
			phx <= 2'h0;
		else if (ext_run)
			phx <= phx + 2'h1;
	end
	// pins idle high between bursts
	assign timer0_count_pin = ~ph0[1];
	assign timer1_count_pin = ~ph1[1];
	// external clock stands still unless asked to run
	assign ext_clk = phx[1];
endmodule

// ---- tb/dual_legacy_counter_timers_tb.sv ----
`timescale 1ns/1ps
`include "dlt_defines.svh"
module dual_legacy_counter_timers_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata, rd;
	logic pin0, pin1, extc, irq0, irq1, t1_ovf;
	logic timer0_gating_select_in = 1'b0, timer1_gating_select_in = 1'b0, req0 = 1'b0, req1 = 1'b0;
	logic ext_run = 1'b0, ack0 = 1'b0, ack1 = 1'b0, clk_en = 1'b1;
	int error_cnt = 0, total_checks = 0, n;
	int div[4] = '{12, 4, 48, 32};

	always #25 aclk = ~aclk;

	dlt_event_model model (.aclk(aclk), .aresetn(aresetn), .req0(req0),
		.req1(req1), .ext_run(ext_run), .timer0_count_pin(pin0),
		.timer1_count_pin(pin1), .ext_clk(extc));

	dlt_timers dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .timer0_count_pin(pin0),
		.timer1_count_pin(pin1), .gating_input_zero(timer0_gating_select_in),
		.gating_input_one(timer1_gating_select_in), .ext_clk(extc), .timer0_irq_ack(ack0),
		.timer1_irq_ack(ack1), .timer0_irq(irq0), .timer1_irq(irq1),
		.timer1_overflow_pulse(t1_ovf));

	task report_and_stop();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task check_word(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task check_bit(input logic got, input logic exp);
		check_word({31'h0, got}, {31'h0, exp});
	endtask

	task axi_write(input logic [7:0] a, input logic [7:0] d);
		int k;
		logic ah, wh, bh;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h0, d};
		wstrb <= 4'h1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		k = 0;
		bh = 1'b0;
		while (!bh && k < 100) begin
			@(negedge aclk);
			ah = awvalid && awready;
			wh = wvalid && wready;
			bh = bvalid;
			rsp = bresp;
			@(posedge aclk);
			if (ah)
				awvalid <= 1'b0;
			if (wh)
				wvalid <= 1'b0;
			k++;
		end
		bready <= 1'b0;
		check_bit(bh, 1'b1);
	endtask

	task axi_read(input logic [7:0] a);
		int k;
		logic ah, rh;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		k = 0;
		rh = 1'b0;
		while (!rh && k < 100) begin
			@(negedge aclk);
			ah = arvalid && arready;
			rh = rvalid;
			rd = rdata;
			rsp = rresp;
			@(posedge aclk);
			if (ah)
				arvalid <= 1'b0;
			k++;
		end
		rready <= 1'b0;
		check_bit(rh, 1'b1);
	endtask

	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		axi_read(a);
		check_word(rd, exp);
	endtask

	task send_edges(input int t, input int cnt);
		@(posedge aclk);
		if (t == 0)
			req0 <= 1'b1;
		else
			req1 <= 1'b1;
		repeat (4 * cnt) @(posedge aclk);
		req0 <= 1'b0;
		req1 <= 1'b0;
		repeat (6) @(posedge aclk);
	endtask

	// waits for the request, then acknowledges it as vectoring would
	task wait_irq(input int t, output int cnt);
		cnt = 0;
		do begin
			@(negedge aclk);
			cnt++;
		end while ((t ? irq1 : irq0) !== 1'b1 && cnt < 300);
		@(posedge aclk);
		if (t)
			ack1 <= 1'b1;
		else
			ack0 <= 1'b1;
		@(posedge aclk);
		ack0 <= 1'b0;
		ack1 <= 1'b0;
	endtask

	task run_case(input int t, input logic [1:0] m, input logic [7:0] lo,
		input logic [7:0] hi, input int ne, input logic [7:0] elo,
		input logic [7:0] ehi);
		logic [7:0] lo_ofs;
		lo_ofs = t ? `DLT_OFS_T1_LOW : `DLT_OFS_T0_LOW;
		axi_write(`DLT_OFS_MODE, t ? {2'b01, m, 4'h0} : {4'h0, 2'b01, m});
		axi_write(lo_ofs, lo);
		axi_write(lo_ofs + 8'h04, hi);
		axi_write(`DLT_OFS_CONTROL, t ? 8'h40 : 8'h10);
		send_edges(t, ne);
		rd_chk(`DLT_OFS_CONTROL, t ? 32'hc0 : 32'h30);
		@(negedge aclk);
		check_bit(t ? irq1 : irq0, 1'b1);
		axi_write(`DLT_OFS_CONTROL, 8'h00);
		@(negedge aclk);
		check_bit(t ? irq1 : irq0, 1'b0);
		axi_read(lo_ofs);
		check_word(rd & (m == 2'b00 ? 32'h1f : 32'hff), {24'h0, elo});
		rd_chk(lo_ofs + 8'h04, {24'h0, ehi});
	endtask

	initial begin
		#(20000 * 50);
		error_cnt++;
		report_and_stop();
	end

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 8; i++)
			rd_chk(8'(i * 4), 32'h0);
		rd_chk(8'h20, 32'h0);
		check_word(rsp, `DLT_RESP_SLVERR);
		axi_write(8'h20, 8'h5a);
		check_word(rsp, `DLT_RESP_SLVERR);
		axi_write(`DLT_OFS_IRQ_CFG, 8'h0f);
		rd_chk(`DLT_OFS_IRQ_CFG, 32'h0f);
		run_case(0, 2'b00, 8'h1e, 8'hff, 3, 8'h01, 8'h00);
		run_case(0, 2'b01, 8'hff, 8'hff, 2, 8'h01, 8'h00);
		run_case(0, 2'b10, 8'hfe, 8'ha0, 3, 8'ha1, 8'ha0);
		run_case(1, 2'b01, 8'hfe, 8'hff, 3, 8'h01, 8'h00);
		run_case(1, 2'b10, 8'hff, 8'h55, 2, 8'h56, 8'h55);
		// gated counting, gating input active high
		axi_write(`DLT_OFS_MODE, 8'h0d);
		axi_write(`DLT_OFS_T0_LOW, 8'h00);
		axi_write(`DLT_OFS_T0_HIGH, 8'h00);
		axi_write(`DLT_OFS_CONTROL, 8'h10);
		send_edges(0, 3);
		rd_chk(`DLT_OFS_T0_LOW, 32'h00);
		@(posedge aclk);
		timer0_gating_select_in <= 1'b1;
		send_edges(0, 2);
		rd_chk(`DLT_OFS_T0_LOW, 32'h02);
		// frozen clock enable: edges ignored, bus stalled
		@(posedge aclk);
		clk_en <= 1'b0;
		send_edges(0, 2);
		@(negedge aclk);
		check_bit(awready, 1'b0);
		@(posedge aclk);
		clk_en <= 1'b1;
		rd_chk(`DLT_OFS_T0_LOW, 32'h02);
		axi_write(`DLT_OFS_CONTROL, 8'h00);
		// split mode, timer 1 parked in mode 3
		axi_write(`DLT_OFS_MODE, 8'h37);
		axi_write(`DLT_OFS_CLOCK, 8'h04);
		axi_write(`DLT_OFS_T0_LOW, 8'hfe);
		axi_write(`DLT_OFS_T0_HIGH, 8'hf0);
		axi_write(`DLT_OFS_T1_LOW, 8'h12);
		axi_write(`DLT_OFS_T1_HIGH, 8'h34);
		axi_write(`DLT_OFS_CONTROL, 8'h50);
		send_edges(0, 3);
		send_edges(1, 3);
		rd_chk(`DLT_OFS_CONTROL, 32'hf0);
		check_bit(irq1, 1'b1);
		wait_irq(1, n);
		rd_chk(`DLT_OFS_CONTROL, 32'h70);
		axi_write(`DLT_OFS_CONTROL, 8'h00);
		rd_chk(`DLT_OFS_T0_LOW, 32'h01);
		rd_chk(`DLT_OFS_T1_LOW, 32'h12);
		rd_chk(`DLT_OFS_T1_HIGH, 32'h34);
		axi_write(`DLT_OFS_T1_LOW, 8'hff);
		axi_write(`DLT_OFS_T1_HIGH, 8'hff);
		axi_write(`DLT_OFS_CLOCK, 8'h0c);
		axi_write(`DLT_OFS_MODE, 8'h17);
		n = 0;
		do begin
			@(negedge aclk);
			n++;
		end while (t1_ovf !== 1'b1 && n < 50);
		check_bit(t1_ovf, 1'b1);
		rd_chk(`DLT_OFS_CONTROL, 32'h00);
		check_bit(irq1, 1'b0);
		// prescaled reload timer: one overflow per prescaled tick
		axi_write(`DLT_OFS_MODE, 8'h32);
		axi_write(`DLT_OFS_T0_LOW, 8'hff);
		axi_write(`DLT_OFS_T0_HIGH, 8'hff);
		axi_write(`DLT_OFS_CONTROL, 8'h10);
		@(posedge aclk);
		ext_run <= 1'b1;
		for (int p = 0; p < 4; p++) begin
			axi_write(`DLT_OFS_CLOCK, 8'(p));
			wait_irq(0, n);
			wait_irq(0, n);
			wait_irq(0, n);
			check_word(n, div[p] - 1);
		end
		axi_write(`DLT_OFS_CONTROL, 8'h00);
		// request needs the enable; vectoring clears the flag
		axi_write(`DLT_OFS_IRQ_CFG, 8'h0e);
		axi_write(`DLT_OFS_CONTROL, 8'h20);
		@(negedge aclk);
		check_bit(irq0, 1'b0);
		axi_write(`DLT_OFS_IRQ_CFG, 8'h0f);
		@(negedge aclk);
		check_bit(irq0, 1'b1);
		wait_irq(0, n);
		rd_chk(`DLT_OFS_CONTROL, 32'h00);
		report_and_stop();
	end
endmodule
